//--- hdl/rsf_defs.vh
`ifndef RSF_DEFS_VH
`define RSF_DEFS_VH

// ==========================================================================
// Special character codes and the loop start data code as seen on the decoder output (byte value)
`define RSF_CODE_FILL        8'h05
`define RSF_CODE_CELL        8'h08
`define RSF_CODE_XCMD        8'h09
`define RSF_CODE_ADDR        8'h0A
`define RSF_CODE_EXCEPT      8'hE0
`define RSF_CODE_LOOP_START  8'h00

// ==========================================================================
// Status encodings {cell_start, special_not_data, violation}
`define RSF_ST_DATA          3'h0
`define RSF_ST_COMMAND       3'h2
`define RSF_ST_EXCEPT        3'h3
`define RSF_ST_CELL          3'h4
`define RSF_ST_ILLEGAL       3'h5
`define RSF_ST_XCMD          3'h6
`define RSF_ST_ADDR          3'h7

// ==========================================================================
// Status field positions
`define RSF_STB_CELL         2
`define RSF_STB_SPECIAL      1
`define RSF_STB_VIOL         0

// ==========================================================================
// Discard policy select values
`define RSF_POL_KEEP_ALL     2'h0
`define RSF_POL_DROP_ADDR    2'h3

// ==========================================================================
// Self-test generator
`define RSF_GEN_W            9
`define RSF_GEN_START        9'h000
`define RSF_GEN_LOOP_LEN     511

// ==========================================================================
// Self-test abort: mismatches within a window of characters
`define RSF_ERR_WINDOW       64
`define RSF_ERR_LIMIT        8

// ==========================================================================
// Marker tracker states
`define RSF_MK_NONE          2'h0
`define RSF_MK_CELL          2'h1
`define RSF_MK_XCMD          2'h2
`define RSF_MK_ADDR          2'h3

`endif

//--- hdl/rsf_rx_format.v
`timescale 1ns/100ps
`include "rsf_defs.vh"

// ==========================================================================
// Small synchronous FIFO with valid/ready on both sides
module rsf_fifo #(
	parameter WIDTH = 11,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             clk,
	input  wire             nrst,
	input  wire             wr_valid,
	output wire             wr_ready,
	input  wire [WIDTH-1:0] wr_data,
	output wire             rd_valid,
	input  wire             rd_ready,
	output wire [WIDTH-1:0] rd_data,
	output wire             full
);
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    wr_ptr_q;
	reg  [AW-1:0]    rd_ptr_q;
	reg  [AW:0]      count_q;
	wire             do_wr;
	wire             do_rd;

	// Handshake terms
	assign full     = (count_q == DEPTH[AW:0]);
	assign wr_ready = ~full;
	assign rd_valid = (count_q != {(AW+1){1'b0}});
	assign rd_data  = mem[rd_ptr_q];
	assign do_wr    = wr_valid & wr_ready;
	assign do_rd    = rd_valid & rd_ready;

	// Storage write
	always @(posedge clk) begin
		if (do_wr) begin
			mem[wr_ptr_q] <= wr_data;
		end
	end

	// Pointers and fill level
	always @(posedge clk) begin
		if (!nrst) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q  <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ?
				            {AW{1'b0}} : wr_ptr_q + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ?
				            {AW{1'b0}} : rd_ptr_q + 1'b1;
			end
			if (do_wr && !do_rd) begin
				count_q <= count_q + 1'b1;
			end else if (do_rd && !do_wr) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule // rsf_fifo

// ==========================================================================
// Receive self-test checker and status formatter
module rsf_rx_format #(
	parameter FIFO_DEPTH = 4,
	parameter FIFO_AW    = 2
) (
	input  wire       clk,
	input  wire       nrst,
	input  wire [7:0] dec_char,
	input  wire       dec_special,
	input  wire       dec_invalid,
	input  wire       dec_valid,
	output wire       dec_ready,
	input  wire       rx_selftest_enable_n,
	input  wire       rx_fifo_enable,
	input  wire       rx_decoder_enable,
	input  wire [1:0] rx_discard_policy_select,
	output wire       rx_out_valid,
	input  wire       rx_out_ready,
	output wire [7:0] rx_out_data,
	output wire       rx_cell_start_flag,
	output wire       rx_special_not_data,
	output wire       rx_violation_flag,
	output wire       rx_fifo_full_n,
	output wire       rx_selftest_synced
);
	localparam WIN_W = 7;
	localparam ERR_W = 4;

	// Output staging register
	reg        stg_valid_q;
	reg  [7:0] stg_data_q;
	reg  [2:0] stg_stat_q;
	reg        stg_valid_d;
	reg  [7:0] stg_data_d;
	reg  [2:0] stg_stat_d;
	// Self-test state
	reg  [`RSF_GEN_W-1:0] gen_q;
	reg  [`RSF_GEN_W-1:0] gen_d;
	reg                   sync_q;
	reg                   sync_d;
	reg  [WIN_W-1:0]      win_cnt_q;
	reg  [WIN_W-1:0]      win_cnt_d;
	reg  [ERR_W-1:0]      err_cnt_q;
	reg  [ERR_W-1:0]      err_cnt_d;
	reg                   full_n_q;
	reg                   full_n_d;
	// Marker tracker
	reg  [1:0] mk_q;
	reg  [1:0] mk_d;
	reg  [7:0] mk_code_q;
	reg  [7:0] mk_code_d;

	wire        selftest;
	wire        fifo_wr_ready;
	wire        fifo_full;
	wire        take;
	wire        stg_push;
	wire        gen_fb;
	wire [`RSF_GEN_W-1:0] gen_next;
	wire        exp_special;
	wire [7:0]  exp_char;
	wire        mismatch;
	wire        is_loop_start;
	wire        enh_on;
	wire        is_marker;
	wire        good_special;

	assign selftest = ~rx_selftest_enable_n;

	// Stage drains into the FIFO; the decoder stalls while the stage is held
	assign stg_push  = stg_valid_q & fifo_wr_ready;
	assign dec_ready = ~stg_valid_q | fifo_wr_ready;
	assign take      = dec_valid & dec_ready;

	// ======================================================================
	// Self-test generator: 9-bit XNOR shift register, all-ones excluded
	assign gen_fb      = ~(gen_q[8] ^ gen_q[4]);
	assign gen_next    = {gen_q[7:0], gen_fb};
	assign exp_special = gen_q[8];
	assign exp_char    = gen_q[7:0];
	// Only character value and kind compared; decoder error flags ignored
	assign mismatch    = (dec_char != exp_char) |
	                     (dec_special != exp_special);
	assign is_loop_start = ~dec_special &
	                       (dec_char == `RSF_CODE_LOOP_START);

	// ======================================================================
	// Formatter qualifiers
	assign enh_on    = rx_fifo_enable & rx_decoder_enable;
	assign good_special = dec_special & ~dec_invalid;
	assign is_marker = enh_on & good_special &
	                   ((dec_char == `RSF_CODE_CELL) |
	                    (dec_char == `RSF_CODE_XCMD) |
	                    (dec_char == `RSF_CODE_ADDR));

	// Self-test sequencing: hunt, compare, loop pulse and abort
	always @* begin
		gen_d     = gen_q;
		sync_d    = sync_q;
		win_cnt_d = win_cnt_q;
		err_cnt_d = err_cnt_q;
		full_n_d  = 1'b1;
		if (!selftest) begin
			gen_d     = `RSF_GEN_START;
			sync_d    = 1'b0;
			win_cnt_d = {WIN_W{1'b0}};
			err_cnt_d = {ERR_W{1'b0}};
		end else if (take) begin
			if (!sync_q) begin
				// Hunt for the loop start character
				if (is_loop_start) begin
					sync_d = 1'b1;
					gen_d  = gen_next;
				end
			end else begin
				gen_d = gen_next;
				if (gen_next == `RSF_GEN_START) begin
					full_n_d = 1'b0;
				end
				// Fixed window of mismatches, restarted every 64 characters
				if (win_cnt_q == `RSF_ERR_WINDOW - 1) begin
					win_cnt_d = {WIN_W{1'b0}};
					err_cnt_d = {{(ERR_W-1){1'b0}}, mismatch};
				end else begin
					win_cnt_d = win_cnt_q + 1'b1;
					err_cnt_d = err_cnt_q + {{(ERR_W-1){1'b0}}, mismatch};
				end
				if (mismatch &&
				    err_cnt_q == `RSF_ERR_LIMIT - 1) begin
					gen_d     = `RSF_GEN_START;
					sync_d    = 1'b0;
					win_cnt_d = {WIN_W{1'b0}};
					err_cnt_d = {ERR_W{1'b0}};
				end
			end
		end
	end

	// Character formatting and marker pairing
	always @* begin
		stg_valid_d = stg_valid_q & ~stg_push;
		stg_data_d  = stg_data_q;
		stg_stat_d  = stg_stat_q;
		mk_d        = mk_q;
		mk_code_d   = mk_code_q;
		if (selftest || !enh_on) begin
			mk_d = `RSF_MK_NONE;
		end
		if (take) begin
			stg_data_d  = dec_char;
			stg_valid_d = 1'b1;
			if (selftest) begin
				// Flag mismatches only once synchronized
				stg_stat_d = {1'b0, dec_special,
				              sync_q & mismatch};
			end else if (enh_on && mk_q != `RSF_MK_NONE) begin
				if (dec_special || dec_invalid) begin
					// Marker followed by special or bad character
					stg_stat_d = `RSF_ST_ILLEGAL;
					stg_data_d = mk_code_q;
				end else if (mk_q == `RSF_MK_ADDR) begin
					stg_stat_d  = `RSF_ST_ADDR;
					stg_valid_d = (rx_discard_policy_select !=
					               `RSF_POL_DROP_ADDR);
				end else if (mk_q == `RSF_MK_XCMD) begin
					stg_stat_d = `RSF_ST_XCMD;
				end else begin
					stg_stat_d = `RSF_ST_CELL;
				end
				mk_d = `RSF_MK_NONE;
			end else if (is_marker) begin
				// Marker is held until its partner character arrives
				stg_valid_d = 1'b0;
				mk_code_d   = dec_char;
				if (dec_char == `RSF_CODE_CELL) begin
					mk_d = `RSF_MK_CELL;
				end else if (dec_char == `RSF_CODE_XCMD) begin
					mk_d = `RSF_MK_XCMD;
				end else begin
					mk_d = `RSF_MK_ADDR;
				end
			end else if (dec_invalid ||
			             (good_special &&
			              dec_char == `RSF_CODE_EXCEPT)) begin
				stg_stat_d = `RSF_ST_EXCEPT;
			end else if (dec_special) begin
				stg_stat_d = `RSF_ST_COMMAND;
				if (enh_on && dec_char == `RSF_CODE_FILL &&
				    rx_discard_policy_select[1]) begin
					stg_valid_d = 1'b0;
				end
			end else begin
				stg_stat_d = `RSF_ST_DATA;
			end
		end
	end

	// Registers
	always @(posedge clk) begin
		if (!nrst) begin
			stg_valid_q <= 1'b0;
			stg_data_q  <= 8'h00;
			stg_stat_q  <= 3'h0;
			gen_q       <= `RSF_GEN_START;
			sync_q      <= 1'b0;
			win_cnt_q   <= {WIN_W{1'b0}};
			err_cnt_q   <= {ERR_W{1'b0}};
			full_n_q    <= 1'b1;
			mk_q        <= `RSF_MK_NONE;
			mk_code_q   <= 8'h00;
		end else begin
			stg_valid_q <= stg_valid_d;
			stg_data_q  <= stg_data_d;
			stg_stat_q  <= stg_stat_d;
			gen_q       <= gen_d;
			sync_q      <= sync_d;
			win_cnt_q   <= win_cnt_d;
			err_cnt_q   <= err_cnt_d;
			full_n_q    <= full_n_d;
			mk_q        <= mk_d;
			mk_code_q   <= mk_code_d;
		end
	end

	// ======================================================================
	// Receive FIFO between formatter and host
	wire [10:0] fifo_rd_data;

	rsf_fifo #(
		.WIDTH (11),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.clk      (clk),
		.nrst     (nrst),
		.wr_valid (stg_valid_q),
		.wr_ready (fifo_wr_ready),
		.wr_data  ({stg_stat_q, stg_data_q}),
		.rd_valid (rx_out_valid),
		.rd_ready (rx_out_ready),
		.rd_data  (fifo_rd_data),
		.full     (fifo_full)
	);

	// Host side outputs
	assign rx_out_data         = fifo_rd_data[7:0];
	assign rx_cell_start_flag  = fifo_rd_data[8 + `RSF_STB_CELL];
	assign rx_special_not_data = fifo_rd_data[8 + `RSF_STB_SPECIAL];
	assign rx_violation_flag   = fifo_rd_data[8 + `RSF_STB_VIOL];
	// Full flag: loop pulse in self-test, FIFO state otherwise
	assign rx_fifo_full_n      = selftest ? full_n_q : ~fifo_full;
	assign rx_selftest_synced  = sync_q;
endmodule // rsf_rx_format

//--- verif/rsf_host_model.sv
`timescale 1ns/100ps
// ==========
// Host logic that pops the receive FIFO and logs each entry
module rsf_host_model (
	input  wire        clk,
	input  wire        stall,
	input  wire        rx_out_valid,
	output logic       rx_out_ready,
	input  wire [10:0] entry
);
	logic [10:0] got [$];

	// Pop while not stalled; ready moves just after the edge
	initial rx_out_ready = 1'b0;
	always @(posedge clk) begin
		if (rx_out_valid && rx_out_ready)
			got.push_back(entry);
		rx_out_ready <= #1 !stall;
	end
endmodule // rsf_host_model

//--- verif/rsf_rx_format_props.sv
`timescale 1ns/100ps
// ==========
// Port checks of the receive formatter
module rsf_rx_format_props (
	input wire       clk,
	input wire       nrst,
	input wire [7:0] dec_char,
	input wire       dec_special,
	input wire       dec_valid,
	input wire       dec_ready,
	input wire       rx_selftest_enable_n,
	input wire       rx_out_valid,
	input wire       rx_out_ready,
	input wire [7:0] rx_out_data,
	input wire       rx_cell_start_flag,
	input wire       rx_special_not_data,
	input wire       rx_violation_flag,
	input wire       rx_fifo_full_n,
	input wire       rx_selftest_synced
);
	// Head status and a taken loop start character
	wire [2:0] st = {rx_cell_start_flag, rx_special_not_data,
		rx_violation_flag};
	wire go = dec_valid & dec_ready & ~dec_special & ~|dec_char;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	AST_RST_IDLE: assert property (disable iff (1'b0) !nrst |=>
		!rx_out_valid && rx_fifo_full_n && !rx_selftest_synced)
		else $error("reset state wrong");
	AST_SYNC_OFF: assert property (rx_selftest_enable_n |=>
		!rx_selftest_synced) else $error("synced outside self-test");
	AST_HUNT: assert property ($rose(rx_selftest_synced) |->
		$past(go)) else $error("synced without loop start");
	AST_ONE_PULSE: assert property (!rx_selftest_enable_n &&
		!rx_fifo_full_n |=> rx_fifo_full_n || rx_selftest_enable_n)
		else $error("loop pulse too long");
	AST_PULSE_SYNC: assert property (!rx_selftest_enable_n &&
		$fell(rx_fifo_full_n) |-> $past(rx_selftest_synced))
		else $error("loop pulse while hunting");
	AST_TAKE_ROOM: assert property (rx_selftest_enable_n &&
		rx_fifo_full_n |-> dec_ready) else $error("refused with room");
	AST_HEAD_HOLD: assert property (rx_out_valid && !rx_out_ready |=>
		rx_out_valid && $stable(rx_out_data) && $stable(st))
		else $error("head changed before pop");
	AST_ILL_MARK: assert property (rx_out_valid && st == 3'h5 |->
		rx_out_data inside {8'h08, 8'h09, 8'h0A})
		else $error("illegal sequence lost its marker");
endmodule // rsf_rx_format_props

//--- verif/rsf_rx_format_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
	mismatches++; $display("[FAIL] %s exp %h seen %h", n, e, a); end end
// ==========
// Testbench of the receive formatter
module rsf_rx_format_tb;
	logic        clk = 1'b0;
	logic        nrst;
	logic [7:0]  dec_char;
	logic        dec_special;
	logic        dec_invalid;
	logic        dec_valid;
	logic        rx_selftest_enable_n;
	logic        rx_fifo_enable;
	logic        rx_decoder_enable;
	logic [1:0]  rx_discard_policy_select;
	logic        stall;
	wire         dec_ready, rx_out_valid, rx_out_ready, rx_fifo_full_n;
	wire [7:0]   rx_out_data;
	wire         rx_cell_start_flag, rx_special_not_data, rx_violation_flag;
	wire         rx_selftest_synced;
	int          mismatches = 0;
	int          num_checks = 0;
	int          pulses = 0;
	logic [8:0]  gen;
	logic [9:0]  w;
	logic [10:0] exq [$];
	// Characters as {special, invalid, byte}, entries as {status, byte}
	logic [9:0]  stim [15] = '{10'h041, 10'h21C, 10'h2E0, 10'h141, 10'h208,
		10'h041, 10'h209, 10'h042, 10'h20A, 10'h043, 10'h208, 10'h205,
		10'h20A, 10'h141, 10'h205};
	logic [10:0] expn [10] = '{11'h041, 11'h21C, 11'h3E0, 11'h341, 11'h441,
		11'h642, 11'h743, 11'h508, 11'h50A, 11'h205};
	logic [9:0]  pstim [4] = '{10'h205, 10'h20A, 10'h055, 10'h041};

	// Design and host reader
	rsf_rx_format i_rsf_rx_format (
		.clk(clk), .nrst(nrst), .dec_char(dec_char),
		.dec_special(dec_special), .dec_invalid(dec_invalid),
		.dec_valid(dec_valid), .dec_ready(dec_ready),
		.rx_selftest_enable_n(rx_selftest_enable_n),
		.rx_fifo_enable(rx_fifo_enable),
		.rx_decoder_enable(rx_decoder_enable),
		.rx_discard_policy_select(rx_discard_policy_select),
		.rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready),
		.rx_out_data(rx_out_data), .rx_cell_start_flag(rx_cell_start_flag),
		.rx_special_not_data(rx_special_not_data),
		.rx_violation_flag(rx_violation_flag),
		.rx_fifo_full_n(rx_fifo_full_n),
		.rx_selftest_synced(rx_selftest_synced));
	rsf_host_model i_rsf_host_model (.clk(clk), .stall(stall),
		.rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready),
		.entry({rx_cell_start_flag, rx_special_not_data, rx_violation_flag,
		rx_out_data}));

	// Clock and loop pulse counter
	always #5 clk = ~clk;
	always @(negedge clk)
		if (!rx_selftest_enable_n && !rx_fifo_full_n) pulses++;

	// Offer a character and hold it until the edge that takes it
	task snd(input [9:0] c);
		logic ok;
		int n;
		dec_special = c[9];
		dec_invalid = c[8];
		dec_char = c[7:0];
		dec_valid = 1'b1;
		n = 0;
		do begin
			ok = dec_ready;
			@(posedge clk) #1;
			n++;
		end while (!ok && n < 40);
		`CHK("taken", 1'b1, ok)
	endtask
	// Leave the input idle for k cycles
	task idle(input int k);
		dec_valid = 1'b0;
		repeat (k) @(posedge clk) #1;
	endtask
	// Let the host catch up, then compare entries in order
	task drain;
		logic [10:0] e, g;
		int n;
		idle(1);
		for (n = 0; n < 900; n++)
			if (i_rsf_host_model.got.size() < exq.size()) @(posedge clk) #1;
		`CHK("count", exq.size(), i_rsf_host_model.got.size())
		while (exq.size() && i_rsf_host_model.got.size()) begin
			e = exq.pop_front();
			g = i_rsf_host_model.got.pop_front();
			`CHK("entry", e, g)
		end
		exq.delete();
		i_rsf_host_model.got.delete();
	endtask
	// Report and end the run
	task conclude;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		nrst = 1'b0;
		dec_char = 8'h00;
		dec_special = 1'b0;
		dec_invalid = 1'b0;
		dec_valid = 1'b0;
		rx_selftest_enable_n = 1'b1;
		rx_fifo_enable = 1'b1;
		rx_decoder_enable = 1'b1;
		rx_discard_policy_select = 2'h0;
		stall = 1'b0;
		repeat (10) @(posedge clk);
		#1;
		nrst = 1'b1;
		`CHK("synced", 1'b0, rx_selftest_synced)
		foreach (stim[i]) snd(stim[i]);
		foreach (expn[i]) exq.push_back(expn[i]);
		drain();
		stall = 1'b1;
		for (int i = 0; i < 5; i++) snd({6'h05, i[3:0]});
		idle(3);
		`CHK("ready", 1'b0, dec_ready)
		`CHK("full_n", 1'b0, rx_fifo_full_n)
		for (int i = 0; i < 5; i++) exq.push_back({7'h05, i[3:0]});
		stall = 1'b0;
		drain();
		for (int p = 3; p >= 1; p--) begin
			rx_discard_policy_select = p[1:0];
			foreach (pstim[i]) snd(pstim[i]);
			if (p == 1) exq.push_back(11'h205);
			if (p != 3) exq.push_back(11'h755);
			exq.push_back(11'h041);
			drain();
		end
		rx_discard_policy_select = 2'h0;
		for (int e = 0; e < 2; e++) begin
			rx_fifo_enable = e[0];
			rx_decoder_enable = !e[0];
			snd(10'h208);
			snd(10'h041);
			exq.push_back(11'h208);
			exq.push_back(11'h041);
			drain();
		end
		rx_fifo_enable = 1'b1;
		rx_decoder_enable = 1'b1;
		rx_selftest_enable_n = 1'b0;
		snd(10'h041);
		exq.push_back(11'h041);
		gen = 9'h000;
		for (int i = 0; i < 512; i++) begin
			w = {gen[8], i == 100, gen[7:0] ^ {7'h00, i == 200}};
			snd(w);
			exq.push_back({1'b0, w[9], i == 200, w[7:0]});
			gen = {gen[7:0], ~(gen[8] ^ gen[4])};
		end
		drain();
		`CHK("pulses", 1, pulses)
		for (int i = 0; i < 16; i++) snd(10'h2FF);
		idle(20);
		`CHK("aborted", 1'b0, rx_selftest_synced)
		i_rsf_host_model.got.delete();
		snd(10'h000);
		idle(2);
		`CHK("resynced", 1'b1, rx_selftest_synced)
		rx_selftest_enable_n = 1'b1;
		idle(2);
		`CHK("normal", 1'b0, rx_selftest_synced)
		conclude();
	end

	// Cut a hang short
	initial begin
		#200000;
		mismatches++;
		conclude();
	end
endmodule // rsf_rx_format_tb

bind rsf_rx_format rsf_rx_format_props i_rsf_rx_format_props (.clk(clk),
	.nrst(nrst), .dec_char(dec_char), .dec_special(dec_special),
	.dec_valid(dec_valid), .dec_ready(dec_ready),
	.rx_selftest_enable_n(rx_selftest_enable_n),
	.rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready),
	.rx_out_data(rx_out_data), .rx_cell_start_flag(rx_cell_start_flag),
	.rx_special_not_data(rx_special_not_data),
	.rx_violation_flag(rx_violation_flag),
	.rx_fifo_full_n(rx_fifo_full_n),
	.rx_selftest_synced(rx_selftest_synced));
